// *** hdl/qio_quad_output.sv ***
`timescale 1ns/1ns
//
// Overview of operation
// - Sample the angle every 100 us and refresh outputs once per period.
// - Each sample is presented as angle data within one sample period.
// - Interpolator emits every intermediate step between successive samples.
// - Output lags the sample by a fixed two sample periods.
// - Never add or drop a pulse, whatever the speed.
// - Index lasts one step, A/B high two steps, period four steps.
// - A and B sit a quarter period apart.
// - Index high only while A and B are both low, or with both high during the startup hold.
// - After power-on reset A, B, index stay high until chip select low.
// - With chip select low at power-up, hold high until settle time ends.
// - Field out of range drives both field flags low together.
// - Approaching magnet lowers rising flag only; receding lowers falling flag only.
// - Flags float in normal operation, pulled high externally.
// - Direction bit reverses counting sense of the angle.
module qio_quad_output
    import qio_pkg::*;
#(
    parameter int SETTLE_CYCLES = POWERUP_SETTLE_CYCLES
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [ANGLE_W-1:0] angle_in,
    input wire logic reverse_direction_bit,
    input wire logic chip_select_n,
    input wire logic field_out_of_range,
    input wire logic field_increasing,
    input wire logic field_decreasing,
    input wire logic field_rising_flag_n_in,
    output logic field_rising_flag_n_out,
    output logic field_rising_flag_n_oe,
    input wire logic field_falling_flag_n_in,
    output logic field_falling_flag_n_out,
    output logic field_falling_flag_n_oe,
    output logic quad_a,
    output logic quad_b,
    output logic quad_index,
    output logic [ANGLE_W-1:0] angle_data,
    output logic angle_data_valid
);

    logic [TICK_W-1:0] tick_cnt_ff;
    logic [TICK_W-1:0] nxt_tick_cnt;
    logic tick;

    logic [SETTLE_W-1:0] settle_cnt_ff;
    logic [SETTLE_W-1:0] nxt_settle_cnt;
    logic settle_done_ff;
    logic nxt_settle_done;

    qio_state_type state_ff;
    qio_state_type nxt_state;

    logic [ANGLE_W-1:0] sample_ff;
    logic [ANGLE_W-1:0] nxt_sample;
    logic [ANGLE_W-1:0] angle_data_ff;
    logic [ANGLE_W-1:0] nxt_angle_data;
    logic angle_valid_ff;
    logic nxt_angle_valid;

    logic [ANGLE_W-1:0] pos_ff;
    logic [ANGLE_W-1:0] nxt_pos;
    logic down_ff;
    logic nxt_down;
    logic [ANGLE_W-1:0] delta;
    logic [ANGLE_W-1:0] step_mag;
    logic step_load;
    logic step;

    logic quad_a_ff;
    logic quad_b_ff;
    logic quad_index_ff;
    logic nxt_quad_a;
    logic nxt_quad_b;
    logic nxt_quad_index;

    logic rising_oe_ff;
    logic falling_oe_ff;
    logic nxt_rising_oe;
    logic nxt_falling_oe;
    logic flag_level_ff;

    // Sample period timebase
    assign tick = (tick_cnt_ff == TICK_W'(SAMPLE_CYCLES - 1));

    always_comb begin
        nxt_tick_cnt = tick ? TICK_RESET : tick_cnt_ff + 1'b1;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tick_cnt_ff <= TICK_RESET;
        end else begin
            tick_cnt_ff <= nxt_tick_cnt;
        end
    end

    // Offset compensation window after power-on reset
    always_comb begin
        nxt_settle_cnt = settle_cnt_ff;
        nxt_settle_done = settle_done_ff;
        if (!settle_done_ff) begin
            if (settle_cnt_ff == SETTLE_W'(SETTLE_CYCLES - 1)) begin
                nxt_settle_done = 1'b1;
            end else begin
                nxt_settle_cnt = settle_cnt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            settle_cnt_ff <= SETTLE_RESET;
            settle_done_ff <= 1'b0;
        end else begin
            settle_cnt_ff <= nxt_settle_cnt;
            settle_done_ff <= nxt_settle_done;
        end
    end

    // Startup hold; only reset brings it back
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            QIO_HOLD: begin
                if (!chip_select_n && settle_done_ff) begin
                    nxt_state = QIO_RUN;
                end
            end
            QIO_RUN: begin
                nxt_state = QIO_RUN;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_ff <= QIO_HOLD;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Sampling and angle data
    always_comb begin
        nxt_sample = sample_ff;
        nxt_angle_data = angle_data_ff;
        nxt_angle_valid = 1'b0;
        if (tick) begin
            nxt_sample = reverse_direction_bit ? ANGLE_W'(-angle_in) : angle_in;
            nxt_angle_data = nxt_sample;
            nxt_angle_valid = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sample_ff <= ANGLE_RESET;
            angle_data_ff <= ANGLE_RESET;
            angle_valid_ff <= 1'b0;
        end else begin
            sample_ff <= nxt_sample;
            angle_data_ff <= nxt_angle_data;
            angle_valid_ff <= nxt_angle_valid;
        end
    end

    // Position follows the previous sample, so steps land one period later
    always_comb begin
        delta = sample_ff - pos_ff;
        step_mag = delta[ANGLE_W-1] ? ANGLE_W'(-delta) : delta;
        step_load = tick && (state_ff == QIO_RUN);
        nxt_down = down_ff;
        nxt_pos = pos_ff;
        if (state_ff == QIO_HOLD) begin
            // Start from the held sample without stepping through the gap
            nxt_pos = sample_ff;
        end else begin
            if (step_load) begin
                nxt_down = delta[ANGLE_W-1];
            end
            if (step) begin
                nxt_pos = down_ff ? pos_ff - 1'b1 : pos_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pos_ff <= ANGLE_RESET;
            down_ff <= 1'b0;
        end else begin
            pos_ff <= nxt_pos;
            down_ff <= nxt_down;
        end
    end

    // Load happens on the tick, so no step of the old period is pending
    qio_stepper u_stepper (
        .clock(clock),
        .rst_n(rst_n),
        .load(step_load),
        .step_count(step_mag),
        .step(step)
    );

    // Quadrature decode of the step position
    always_comb begin
        nxt_quad_a = QUAD_RESET;
        nxt_quad_b = QUAD_RESET;
        nxt_quad_index = QUAD_RESET;
        if (state_ff == QIO_RUN) begin
            nxt_quad_a = pos_ff[QUAD_A_HI_BIT] ^ pos_ff[QUAD_A_LO_BIT];
            nxt_quad_b = pos_ff[QUAD_B_BIT];
            nxt_quad_index = (pos_ff == INDEX_POS);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            quad_a_ff <= QUAD_RESET;
            quad_b_ff <= QUAD_RESET;
            quad_index_ff <= QUAD_RESET;
        end else begin
            quad_a_ff <= nxt_quad_a;
            quad_b_ff <= nxt_quad_b;
            quad_index_ff <= nxt_quad_index;
        end
    end

    // Field flags; out of range overrides the movement hints
    always_comb begin
        nxt_rising_oe = FLAG_OE_RESET;
        nxt_falling_oe = FLAG_OE_RESET;
        if (field_out_of_range) begin
            nxt_rising_oe = 1'b1;
            nxt_falling_oe = 1'b1;
        end else if (field_increasing && !field_decreasing) begin
            nxt_rising_oe = 1'b1;
        end else if (field_decreasing && !field_increasing) begin
            nxt_falling_oe = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rising_oe_ff <= FLAG_OE_RESET;
            falling_oe_ff <= FLAG_OE_RESET;
            flag_level_ff <= FLAG_DRIVE_LEVEL;
        end else begin
            rising_oe_ff <= nxt_rising_oe;
            falling_oe_ff <= nxt_falling_oe;
            flag_level_ff <= FLAG_DRIVE_LEVEL;
        end
    end

    assign quad_a = quad_a_ff;
    assign quad_b = quad_b_ff;
    assign quad_index = quad_index_ff;
    assign angle_data = angle_data_ff;
    assign angle_data_valid = angle_valid_ff;
    assign field_rising_flag_n_out = flag_level_ff;
    assign field_rising_flag_n_oe = rising_oe_ff;
    assign field_falling_flag_n_out = flag_level_ff;
    assign field_falling_flag_n_oe = falling_oe_ff;

endmodule

// *** hdl/qio_pkg.sv ***
package qio_pkg;

    // Clock and sample timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int SAMPLE_PERIOD_US = 100;
    localparam int SAMPLE_CYCLES = (SAMPLE_PERIOD_US * 1000) / CLK_PERIOD_NS;
    localparam int OUTPUT_LATENCY_SAMPLES = 2;

    // Power-up offset compensation window, rounded up to whole cycles
    localparam int POWERUP_SETTLE_US = 20000;
    localparam int POWERUP_SETTLE_CYCLES = (POWERUP_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Widths
    localparam int ANGLE_W = 8;
    localparam int TICK_W = 10;
    localparam int ACC_W = 11;
    localparam int SETTLE_W = 18;

    // Quadrature decode of the step position
    localparam int QUAD_A_HI_BIT = 1;
    localparam int QUAD_A_LO_BIT = 0;
    localparam int QUAD_B_BIT = 1;
    localparam logic [ANGLE_W-1:0] INDEX_POS = 8'h00;

    // Reset values
    localparam logic QUAD_RESET = 1'b1;
    localparam logic FLAG_OE_RESET = 1'b0;
    localparam logic FLAG_DRIVE_LEVEL = 1'b0;
    localparam logic [ANGLE_W-1:0] ANGLE_RESET = 8'h00;
    localparam logic [TICK_W-1:0] TICK_RESET = 10'h000;
    localparam logic [ACC_W-1:0] ACC_RESET = 11'h000;
    localparam logic [SETTLE_W-1:0] SETTLE_RESET = 18'h00000;

    typedef enum logic {
        QIO_HOLD,
        QIO_RUN
    } qio_state_type;

endpackage

// *** hdl/qio_stepper.sv ***
`timescale 1ns/1ns
module qio_stepper
    import qio_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [ANGLE_W-1:0] step_count,
    output logic step
);

    logic [ACC_W-1:0] acc_ff;
    logic [ACC_W-1:0] nxt_acc;
    logic [ANGLE_W-1:0] rate_ff;
    logic [ANGLE_W-1:0] nxt_rate;
    logic step_ff;
    logic nxt_step;
    logic [ACC_W-1:0] acc_sum;

    // Even spreading: exactly rate steps emerge in SAMPLE_CYCLES cycles
    // Preload of two rates lands the last step early enough to settle before the next tick
    always_comb begin
        nxt_rate = rate_ff;
        nxt_acc = acc_ff;
        nxt_step = 1'b0;
        acc_sum = acc_ff + ACC_W'(rate_ff);
        if (load) begin
            nxt_rate = step_count;
            nxt_acc = ACC_W'({step_count, 1'b0});
        end else if (acc_sum >= ACC_W'(SAMPLE_CYCLES)) begin
            nxt_acc = acc_sum - ACC_W'(SAMPLE_CYCLES);
            nxt_step = 1'b1;
        end else begin
            nxt_acc = acc_sum;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            acc_ff <= ACC_RESET;
            rate_ff <= ANGLE_RESET;
            step_ff <= 1'b0;
        end else begin
            acc_ff <= nxt_acc;
            rate_ff <= nxt_rate;
            step_ff <= nxt_step;
        end
    end

    assign step = step_ff;

endmodule

// *** testbench/qio_asserts.sv ***
`timescale 1ns/1ns
module qio_asserts (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic chip_select_n,
    input wire logic field_out_of_range,
    input wire logic field_increasing,
    input wire logic field_decreasing,
    input wire logic field_rising_flag_n_oe,
    input wire logic field_falling_flag_n_oe,
    input wire logic quad_a,
    input wire logic quad_b,
    input wire logic quad_index,
    input wire logic angle_data_valid
);
    logic hi;
    logic cs_ff, run_ff, got_ff;
    int gap_ff;
    assign hi = quad_a & quad_b & quad_index;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cs_ff <= 1'b0;
            run_ff <= 1'b0;
            got_ff <= 1'b0;
            gap_ff <= 0;
        end else begin
            cs_ff <= cs_ff | ~chip_select_n;
            run_ff <= run_ff | ~hi;
            got_ff <= got_ff | angle_data_valid;
            gap_ff <= angle_data_valid ? 0 : gap_ff + 1;
        end
    end
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    cs_hold_a: assert property (!cs_ff |-> hi) else $error("hold left early");
    idx_ab_a: assert property (quad_index |-> hi || (!quad_a && !quad_b)) else $error("index with A or B");
    never_hi_a: assert property (run_ff |-> !hi) else $error("all high in run");
    one_step_a: assert property (run_ff |=> $stable(quad_a) || $stable(quad_b))
        else $error("A and B moved together");
    rate_a: assert property (got_ff |-> angle_data_valid == (gap_ff == 999))
        else $error("sample spacing");
    both_flag_a: assert property (field_out_of_range |=> field_rising_flag_n_oe && field_falling_flag_n_oe)
        else $error("range flags");
    approach_a: assert property (field_increasing && !field_decreasing && !field_out_of_range
        |=> field_rising_flag_n_oe && !field_falling_flag_n_oe) else $error("approach flag");
    flags_free_a: assert property (!field_out_of_range && !field_increasing && !field_decreasing
        |=> !field_rising_flag_n_oe && !field_falling_flag_n_oe) else $error("flags driven");
    cover property ($fell(hi));
    cover property (run_ff && $rose(quad_index));
    cover property (field_rising_flag_n_oe && field_falling_flag_n_oe);
endmodule

// *** testbench/qio_rx_model.sv ***
`timescale 1ns/1ns
module qio_rx_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic quad_a,
    input wire logic quad_b,
    input wire logic quad_index,
    output logic [7:0] count_ff,
    output logic fail_ff,
    output logic skip_ff
);
    logic [1:0] step;
    logic [1:0] prev_ff;
    assign step = {quad_b, quad_a ^ quad_b} - prev_ff;
    always_ff @(posedge clock) begin
        prev_ff <= {quad_b, quad_a ^ quad_b};
        fail_ff <= !rst_n || (quad_a && quad_b && quad_index);
        // Leaving the all-high state is a jump, not a count
        if (!rst_n || fail_ff) begin
            count_ff <= 8'h00;
        end else begin
            count_ff <= count_ff + 8'(step == 2'h1) - 8'(step == 2'h3);
        end
        if (!rst_n) begin
            skip_ff <= 1'b0;
        end else if (!fail_ff) begin
            skip_ff <= skip_ff | (step == 2'h2);
        end
    end
endmodule

// *** testbench/test_qio_quad_output.sv ***
`timescale 1ns/1ns
module test_qio_quad_output import qio_pkg::*;;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic cs_n = 1'b1;
    logic rev = 1'b0;
    logic [2:0] fld = 3'h0;
    logic [7:0] ang = 8'h00;
    logic [7:0] cur = 8'h00;
    logic [7:0] adata, cnt;
    logic ro, roe, fo, foe, a, b, x, vld, fail, skip;
    wire rpin = roe ? ro : 1'b1;
    wire fpin = foe ? fo : 1'b1;
    int n_fail = 0;
    int samples_checked = 0;
    always #50 clock = ~clock;
    qio_quad_output #(.SETTLE_CYCLES(20)) u_dut (.clock(clock), .rst_n(rst_n), .angle_in(ang),
        .reverse_direction_bit(rev), .chip_select_n(cs_n), .field_out_of_range(fld[2]),
        .field_increasing(fld[1]), .field_decreasing(fld[0]), .field_rising_flag_n_in(rpin),
        .field_rising_flag_n_out(ro), .field_rising_flag_n_oe(roe), .field_falling_flag_n_in(fpin),
        .field_falling_flag_n_out(fo), .field_falling_flag_n_oe(foe), .quad_a(a), .quad_b(b),
        .quad_index(x), .angle_data(adata), .angle_data_valid(vld));
    qio_rx_model u_rx (.clock(clock), .rst_n(rst_n), .quad_a(a), .quad_b(b), .quad_index(x),
        .count_ff(cnt), .fail_ff(fail), .skip_ff(skip));
    task automatic close_out();
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [15:0] q3();
        return 16'({a, b, x});
    endfunction
    function automatic logic [15:0] exp_q(logic [7:0] p);
        return 16'({p[1] ^ p[0], p[1], p == 8'h00});
    endfunction
    task automatic tick(int n);
        repeat (n) @(posedge clock);
    endtask
    // Skips the edge of the call so a stale pulse is never taken
    task automatic wait_vld(output int k);
        k = 0;
        do begin
            @(posedge clock);
            @(negedge clock);
            k++;
        end while (vld !== 1'b1 && k < 1100);
        if (k >= 1100) begin
            n_fail++;
            $display("CHECK FAILED sample pulse expected 1 seen none");
            close_out();
        end
    endtask
    task automatic t_hold();
        tick(60);
        @(negedge clock);
        chk("hold", 16'h0007, q3());
        chk("rx fail", 16'h0001, 16'(fail));
        @(posedge clock);
        cs_n <= 1'b0;
        tick(3);
        @(negedge clock);
        chk("release", 16'h0001, q3());
    endtask
    task automatic t_move(logic [7:0] v, logic r);
        logic [7:0] s, c0, e;
        logic [15:0] q0;
        int k;
        s = r ? 8'h00 - v : v;
        @(posedge clock);
        ang <= v;
        rev <= r;
        wait_vld(k);
        chk("angle data", 16'(s), 16'(adata));
        c0 = cnt;
        q0 = q3();
        wait_vld(k);
        chk("period", 16'h03E8, 16'(k));
        chk("held", q0, q3());
        wait_vld(k);
        chk("position", exp_q(s), q3());
        // Receiver counts one edge after the outputs move
        @(posedge clock);
        @(negedge clock);
        e = c0 + s - cur;
        chk("steps", 16'(e), 16'(cnt));
        chk("gray", 16'h0000, 16'(skip));
        cur = s;
    endtask
    task automatic t_flags();
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            fld <= 3'(i);
            tick(2);
            @(negedge clock);
            chk("flags", (16'h00DB >> (2 * i)) & 16'h0003, 16'({rpin, fpin}));
        end
    endtask
    task automatic t_cs_low();
        int k;
        @(posedge clock);
        rst_n <= 1'b0;
        tick(6);
        rst_n <= 1'b1;
        k = 0;
        do begin
            @(negedge clock);
            k++;
        end while (q3() == 16'h0007 && k < 40);
        chk("settle hold", 16'h0001, 16'(k > 20 && k < 30));
    endtask
    initial begin
        tick(6);
        rst_n <= 1'b1;
        t_hold();
        t_move(8'h7F, 1'b0);
        t_move(8'h1B, 1'b0);
        t_move(8'h05, 1'b1);
        t_move(8'h02, 1'b0);
        t_flags();
        t_cs_low();
        close_out();
    end
endmodule
bind qio_quad_output qio_asserts u_chk (.clock(clock), .rst_n(rst_n), .chip_select_n(chip_select_n),
    .field_out_of_range(field_out_of_range), .field_increasing(field_increasing),
    .field_decreasing(field_decreasing), .field_rising_flag_n_oe(field_rising_flag_n_oe),
    .field_falling_flag_n_oe(field_falling_flag_n_oe), .quad_a(quad_a), .quad_b(quad_b),
    .quad_index(quad_index), .angle_data_valid(angle_data_valid));
